/* hdl/scsi_arb_bus_control.sv */
// arbitration, selection and bus control registers of one scsi function
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module scsi_arb_bus_control
  import scsi_ctrl_pkg::*;
#(
  parameter int         SEL_TIMEOUT = SEL_TIMEOUT_CYC,
  parameter logic [2:0] OWN_ID      = 3'h7
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wrData,
  input  wire logic       wrStrobe,
  input  wire logic       rdStrobe,
  output logic      [7:0] rdData,
  input  wire logic       busyIn,
  input  wire logic       selIn,
  input  wire logic       ioIn,
  input  wire logic       atnIn,
  input  wire logic [7:0] dataIn,
  input  wire logic       parityIn,
  input  wire logic       reqIn,
  input  wire logic       dtMode,
  input  wire logic       crcReqIn,
  input  wire logic       crcOkIn,
  input  wire logic       crcPendIn,
  input  wire logic       respondSelIn,
  input  wire logic       discExpected,
  input  wire logic       phaseChange,
  output logic            busyOut,
  output logic            selOut,
  output logic            atnOut,
  output logic            ackOut,
  output logic            rstOut,
  output logic      [7:0] dataOut,
  output logic            parityOut,
  output logic            dataOe,
  output logic            haltXfer
);

  typedef enum logic [2:0] {
    S_IDLE, S_WAIT_FREE, S_ARB, S_HOLD, S_SETTLE, S_SELECT
  } arb_state_e;

  arb_state_e  state_ff, nxt_state;
  logic [7:0]  ctrl0_ff, nxt_ctrl0;
  logic [7:0]  ctrl1_ff, nxt_ctrl1;
  logic [7:0]  latch_ff, nxt_latch;
  logic [7:0]  rd_ff,    nxt_rd;
  logic        won_ff,   nxt_won;
  logic        lost_ff,  nxt_lost;
  logic        abort_ff, nxt_abort;
  logic        parErr_ff, nxt_parErr;
  logic        errAtn_ff, nxt_errAtn;
  logic        ack_ff,   nxt_ack;
  logic        halt_ff,  nxt_halt;
  logic        armed_ff, nxt_armed;
  logic [31:0] cnt_ff,   nxt_cnt;

  logic        busFree, higherId, lostNow, rxErr, role, isTarget;
  logic        wrCtrl0, wrCtrl1, fullArb, arbDone, selDone, selTimeout;
  logic        discNow;

  // odd parity bit over one byte
  function automatic logic odd_par(input logic [7:0] d);
    odd_par = ~(^d);
  endfunction

  // any id above our own present on the data lines
  function automatic logic above_id(input logic [7:0] d, input logic [2:0] id);
    logic [7:0] mask;
    mask = 8'hFF << id;
    above_id = |(d & mask & ~(8'h01 << id));
  endfunction

  // bus observation and decoded strobes
  assign busFree  = !busyIn && !selIn;
  assign higherId = above_id(dataIn, OWN_ID);
  assign role     = ctrl0_ff[ROLE_BIT];
  assign isTarget = role;
  assign fullArb  = ctrl0_ff[ARB_HI:ARB_LO] == ARB_FULL;
  assign wrCtrl0  = wrStrobe && addr == OFF_CTRL_ZERO;
  assign wrCtrl1  = wrStrobe && addr == OFF_CTRL_ONE;
  assign lostNow  = selIn || (fullArb && higherId);
  assign arbDone  = state_ff == S_ARB && cnt_ff == 32'(ARB_DELAY_CYC);
  assign selDone  = state_ff == S_SELECT && busyIn;
  assign selTimeout = state_ff == S_SELECT && !busyIn
                      && cnt_ff == 32'(SEL_TIMEOUT);
  assign discNow  = ctrl1_ff[CONN_BIT] && busFree && state_ff == S_IDLE;

  // receive checking: parity on async/st, crc on dt; off when disabled
  always_comb begin
    rxErr = 1'b0;
    if (ctrl0_ff[CHKEN_BIT]) begin
      if (!dtMode && reqIn && odd_par(dataIn) != parityIn)
        rxErr = 1'b1;
      if (dtMode && crcReqIn && !crcOkIn)
        rxErr = 1'b1;
    end
  end

  // next state of the arbitration engine and all registers except the acknowledge
  always_comb begin
    nxt_state  = state_ff;
    nxt_ctrl0  = ctrl0_ff;
    nxt_ctrl1  = ctrl1_ff;
    nxt_latch  = latch_ff;
    nxt_won    = won_ff;
    nxt_lost   = lost_ff;
    nxt_abort  = abort_ff;
    nxt_parErr = parErr_ff;
    nxt_errAtn = errAtn_ff;
    nxt_halt   = halt_ff;
    nxt_armed  = armed_ff;
    nxt_cnt    = cnt_ff + 32'h1;
    nxt_rd     = 8'h00;
    // register writes; hardware events below take precedence
    if (wrCtrl0) begin
      nxt_ctrl0 = wrData;
      nxt_ctrl0[CRCPEND_BIT] = 1'b0;
    end
    if (wrCtrl1) begin
      nxt_ctrl1 = {1'b0, wrData[6:1], 1'b0};
    end
    if (wrStrobe && addr == OFF_OUT_LATCH)
      nxt_latch = wrData;
    if (wrStrobe && addr == OFF_HOST_HOST_INTERRUPT_STATUS_ZERO)
      nxt_abort = wrData[ABORT_BIT];
    // reads of status clear them; a coincident set wins
    if (rdStrobe && addr == OFF_INT_STAT0)
      nxt_parErr = 1'b0;
    if (rdStrobe && addr == OFF_BUS_STAT0) begin
      nxt_won  = 1'b0;
      nxt_lost = 1'b0;
    end
    if (rxErr)
      nxt_parErr = 1'b1;
    // initiator: auto attention, transfer keeps running
    if (rxErr && !isTarget && ctrl0_ff[AUTOATN_BIT])
      nxt_errAtn = 1'b1;
    // target halt on error or attention unless disabled
    if (isTarget && !ctrl1_ff[NOHALT_BIT] && (rxErr || atnIn))
      nxt_halt = 1'b1;
    if (!isTarget || ctrl1_ff[NOHALT_BIT] || phaseChange)
      nxt_halt = 1'b0;
    if (phaseChange)
      nxt_errAtn = 1'b0;
    // disconnect seen on an idle connected bus
    if (discNow) begin
      nxt_ctrl1[CONN_BIT] = 1'b0;
      nxt_errAtn = 1'b0;
      if (discExpected)
        nxt_armed = 1'b1;
      else
        nxt_ctrl1[IMMARB_BIT] = 1'b0;
    end
    if (respondSelIn)
      nxt_ctrl1[CONN_BIT] = 1'b1;
    unique case (state_ff)
      S_IDLE: begin
        nxt_cnt = 32'h0;
        if (ctrl0_ff[START_BIT]) begin
          nxt_state = S_WAIT_FREE;
        end else if (ctrl1_ff[IMMARB_BIT] && armed_ff) begin
          nxt_state = S_WAIT_FREE;
        end
      end
      S_WAIT_FREE: begin
        nxt_cnt = 32'h0;
        if (busFree)
          nxt_state = S_ARB;
      end
      S_ARB: begin
        if (lostNow) begin
          nxt_lost = 1'b1;
          nxt_cnt  = 32'h0;
          if (ctrl1_ff[IMMARB_BIT] && abort_ff) begin
            nxt_ctrl1[IMMARB_BIT] = 1'b0;
            nxt_armed = 1'b0;
            nxt_state = S_IDLE;
          end else if (fullArb || ctrl1_ff[IMMARB_BIT]) begin
            nxt_state = S_WAIT_FREE;
          end else begin
            nxt_ctrl0[START_BIT] = 1'b0;
            nxt_state = S_IDLE;
          end
        end else if (arbDone) begin
          nxt_won = 1'b1;
          nxt_ctrl1[CONN_BIT] = 1'b1;
          nxt_armed = 1'b0;
          nxt_cnt   = 32'h0;
          if (ctrl1_ff[IMMARB_BIT])
            nxt_state = S_HOLD;
          else if (fullArb)
            nxt_state = S_SETTLE;
          else begin
            nxt_ctrl0[START_BIT] = 1'b0;
            nxt_state = S_IDLE;
          end
        end
      end
      S_HOLD: begin
        nxt_cnt = 32'h0;
        if (!ctrl1_ff[IMMARB_BIT]) begin
          nxt_ctrl1[CONN_BIT] = 1'b0;
          nxt_state = S_IDLE;
        end else if (ctrl0_ff[START_BIT]) begin
          nxt_state = S_SETTLE;
        end
      end
      S_SETTLE: begin
        if (cnt_ff == 32'(SETTLE_CYC)) begin
          nxt_cnt   = 32'h0;
          nxt_state = S_SELECT;
        end
      end
      S_SELECT: begin
        if (selDone || selTimeout) begin
          nxt_ctrl0[START_BIT]  = 1'b0;
          nxt_ctrl1[IMMARB_BIT] = 1'b0;
          if (selTimeout)
            nxt_ctrl1[CONN_BIT] = 1'b0;
          nxt_state = S_IDLE;
        end
      end
    endcase
    // read data stands one cycle after the strobe
    if (rdStrobe) begin
      unique case (addr)
        OFF_CTRL_ZERO: begin
          nxt_rd = ctrl0_ff;
          nxt_rd[CRCPEND_BIT] = crcPendIn;
        end
        OFF_CTRL_ONE:    nxt_rd = ctrl1_ff;
        OFF_OUT_LATCH:   nxt_rd = latch_ff;
        OFF_INT_STAT0:   nxt_rd = {7'h00, parErr_ff};
        OFF_BUS_STAT0:   nxt_rd = {4'h0, lost_ff, won_ff, 2'h0};
        OFF_HOST_HOST_INTERRUPT_STATUS_ZERO: nxt_rd = {abort_ff, 7'h00};
        default:         nxt_rd = 8'h00;
      endcase
    end
  end

  // state registers
  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff  <= S_IDLE;
      ctrl0_ff  <= CTRL_ZERO_RST;
      ctrl1_ff  <= CTRL_ONE_RST;
      latch_ff  <= LATCH_RST;
      rd_ff     <= 8'h00;
      won_ff    <= 1'b0;
      lost_ff   <= 1'b0;
      abort_ff  <= 1'b0;
      parErr_ff <= 1'b0;
      errAtn_ff <= 1'b0;
      halt_ff   <= 1'b0;
      armed_ff  <= 1'b0;
      cnt_ff    <= 32'h0;
    end else begin
      state_ff  <= nxt_state;
      ctrl0_ff  <= nxt_ctrl0;
      ctrl1_ff  <= nxt_ctrl1;
      latch_ff  <= nxt_latch;
      rd_ff     <= nxt_rd;
      won_ff    <= nxt_won;
      lost_ff   <= nxt_lost;
      abort_ff  <= nxt_abort;
      parErr_ff <= nxt_parErr;
      errAtn_ff <= nxt_errAtn;
      halt_ff   <= nxt_halt;
      armed_ff  <= nxt_armed;
      cnt_ff    <= nxt_cnt;
    end
  end

  // initiator acknowledge: one cycle per request, released a cycle later
  always_comb begin
    nxt_ack = reqIn && !isTarget && !ack_ff;
  end

  always_ff @(posedge clk) begin
    if (reset)
      ack_ff <= 1'b0;
    else
      ack_ff <= nxt_ack;
  end

  // bus drive: id during arbitration and selection, latch when enabled and direction fits
  always_comb begin
    busyOut = state_ff == S_ARB || state_ff == S_HOLD
              || state_ff == S_SETTLE;
    selOut  = state_ff == S_HOLD || state_ff == S_SETTLE
              || state_ff == S_SELECT;
    atnOut  = errAtn_ff
              || (state_ff == S_SELECT && !isTarget
                  && ctrl0_ff[SELATN_BIT]);
    if (state_ff == S_ARB || selOut) begin
      dataOut = 8'h01 << OWN_ID;
      dataOe  = 1'b1;
    end else begin
      dataOut = latch_ff;
      dataOe  = ctrl1_ff[DRVDATA_BIT]
                && (isTarget ? ioIn : !ioIn);
    end
    parityOut = odd_par(dataOut) ^ ctrl1_ff[BADPAR_BIT];
  end

  assign rstOut   = ctrl1_ff[BUSRST_BIT];
  assign ackOut   = ack_ff;
  assign haltXfer = halt_ff;
  assign rdData   = rd_ff;

  // checks
  a_par_report: assert property (@(posedge clk) disable iff (reset)
    (!dtMode && reqIn && ctrl0_ff[CHKEN_BIT]
     && odd_par(dataIn) != parityIn) |=> parErr_ff)
    else $error("parity error not reported");
  a_crc_report: assert property (@(posedge clk) disable iff (reset)
    (dtMode && crcReqIn && !crcOkIn && ctrl0_ff[CHKEN_BIT])
    |=> parErr_ff)
    else $error("crc error not reported");
  a_no_report: assert property (@(posedge clk) disable iff (reset)
    (!ctrl0_ff[CHKEN_BIT] && !parErr_ff && !wrCtrl0)
    |=> !parErr_ff)
    else $error("error reported while checking disabled");
  a_sel_atn: assert property (@(posedge clk) disable iff (reset)
    (state_ff == S_SELECT && !isTarget && ctrl0_ff[SELATN_BIT])
    |-> atnOut && selOut)
    else $error("attention missing during selection");
  a_timeout_drop: assert property (@(posedge clk) disable iff (reset)
    (selTimeout && !errAtn_ff) |=> (!selOut && !atnOut))
    else $error("select and attention not released together");
  a_auto_atn: assert property (@(posedge clk) disable iff (reset)
    (rxErr && !isTarget && ctrl0_ff[AUTOATN_BIT] && reqIn)
    |=> atnOut && ackOut)
    else $error("attention not raised before ack release");
  a_start_clear: assert property (@(posedge clk) disable iff (reset)
    (selDone && !wrCtrl0) |=> !ctrl0_ff[START_BIT])
    else $error("start bit not cleared after sequence");
  a_win_conn: assert property (@(posedge clk) disable iff (reset)
    (arbDone && !lostNow) |=> ctrl1_ff[CONN_BIT] && won_ff)
    else $error("connected not set on won arbitration");
  a_rst_follow: assert property (@(posedge clk) disable iff (reset)
    wrCtrl1 |=> rstOut == $past(wrData[BUSRST_BIT]))
    else $error("bus reset line does not follow bit");
  a_bad_par: assert property (@(posedge clk) disable iff (reset)
    ctrl1_ff[BADPAR_BIT] |-> (^{dataOut, parityOut}) == 1'b0)
    else $error("forced parity is not even");
  a_target_halt: assert property (@(posedge clk) disable iff (reset)
    (isTarget && !ctrl1_ff[NOHALT_BIT] && atnIn && !phaseChange
     && !wrCtrl0 && !wrCtrl1) |=> haltXfer)
    else $error("target did not halt on attention");
  a_start_arb: assert property (@(posedge clk) disable iff (reset)
    (state_ff == S_IDLE && ctrl0_ff[START_BIT])
    |=> state_ff == S_WAIT_FREE ##1 state_ff != S_IDLE)
    else $error("start did not launch arbitration");
  c_full_sel: cover property (@(posedge clk) disable iff (reset) selDone);
  c_timeout:  cover property (@(posedge clk) disable iff (reset) selTimeout);
  c_imm_hold: cover property (@(posedge clk) disable iff (reset)
    state_ff == S_HOLD);
  c_lost:     cover property (@(posedge clk) disable iff (reset)
    state_ff == S_ARB && lostNow);

endmodule

/* include/scsi_ctrl_pkg.sv */
// package: register map, field layout, reset values and timing for the block
package scsi_ctrl_pkg;

  // register offsets (byte addresses on the register port)
  localparam logic [7:0] OFF_CTRL_ZERO   = 8'h00;
  localparam logic [7:0] OFF_CTRL_ONE    = 8'h01;
  localparam logic [7:0] OFF_BUS_STAT0   = 8'h0E;
  localparam logic [7:0] OFF_HOST_HOST_INTERRUPT_STATUS_ZERO = 8'h14;
  localparam logic [7:0] OFF_INT_STAT0   = 8'h42;
  localparam logic [7:0] OFF_OUT_LATCH   = 8'h54;

  // scsi_bus_control_zero fields
  localparam int ARB_HI      = 7;
  localparam int ARB_LO      = 6;
  localparam int START_BIT   = 5;
  localparam int SELATN_BIT  = 4;
  localparam int CHKEN_BIT   = 3;
  localparam int CRCPEND_BIT = 2;
  localparam int AUTOATN_BIT = 1;
  localparam int ROLE_BIT    = 0;

  // scsi_bus_control_one fields
  localparam int DRVDATA_BIT = 6;
  localparam int NOHALT_BIT  = 5;
  localparam int CONN_BIT    = 4;
  localparam int BUSRST_BIT  = 3;
  localparam int BADPAR_BIT  = 2;
  localparam int IMMARB_BIT  = 1;

  // status fields
  localparam int WON_BIT     = 2;
  localparam int LOST_BIT    = 3;
  localparam int ABORT_BIT   = 7;
  localparam int PARERR_BIT  = 0;

  // reset values
  localparam logic [7:0] CTRL_ZERO_RST = 8'hC0;
  localparam logic [7:0] CTRL_ONE_RST  = 8'h00;
  localparam logic [7:0] LATCH_RST     = 8'h00;

  // arbitration mode encodings
  localparam logic [1:0] ARB_SIMPLE = 2'h0;
  localparam logic [1:0] ARB_FULL   = 2'h3;

  // timing
  localparam int CLK_PERIOD_NS    = 100;
  localparam int ARB_DELAY_NS     = 2400;
  localparam int SETTLE_NS        = 1200;
  localparam int ARB_DELAY_CYC    =
    (ARB_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYC       =
    (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SEL_TIMEOUT_MS   = 250;
  localparam int SEL_TIMEOUT_CYC  =
    SEL_TIMEOUT_MS * (1000000 / CLK_PERIOD_NS);

endpackage

/* test/scsi_arb_bus_control_test.sv */
// self-checking bench for the arbitration and bus control block
`timescale 1ns/1ps
module scsi_arb_bus_control_test;
  import scsi_ctrl_pkg::*;
  logic       clk, reset, wrStrobe, rdStrobe, busyIn, selIn, ioIn, atnIn;
  logic       parityIn, reqIn, dtMode, crcReqIn, crcOkIn, crcPendIn;
  logic       respondSelIn, discExpected, phaseChange, busyOut, selOut;
  logic       atnOut, ackOut, rstOut, parityOut, dataOe, haltXfer, prevAtn;
  logic [7:0] addr, wrData, rdData, dataIn, dataOut, v;
  int         errTotal, numChecks, cycleCnt, n;

  scsi_arb_bus_control #(.SEL_TIMEOUT(50)) dut (
    .clk(clk), .reset(reset), .addr(addr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .busyIn(busyIn), .selIn(selIn), .ioIn(ioIn), .atnIn(atnIn),
    .dataIn(dataIn), .parityIn(parityIn), .reqIn(reqIn),
    .dtMode(dtMode), .crcReqIn(crcReqIn), .crcOkIn(crcOkIn),
    .crcPendIn(crcPendIn), .respondSelIn(respondSelIn),
    .discExpected(discExpected), .phaseChange(phaseChange),
    .busyOut(busyOut), .selOut(selOut), .atnOut(atnOut),
    .ackOut(ackOut), .rstOut(rstOut), .dataOut(dataOut),
    .parityOut(parityOut), .dataOe(dataOe), .haltXfer(haltXfer));

  scsi_far_side far (
    .clk(clk), .selOut(selOut), .busyOut(busyOut), .busyIn(busyIn),
    .selIn(selIn), .ioIn(ioIn), .atnIn(atnIn), .dataIn(dataIn),
    .parityIn(parityIn), .reqIn(reqIn), .dtMode(dtMode),
    .crcReqIn(crcReqIn), .crcOkIn(crcOkIn), .crcPendIn(crcPendIn),
    .respondSelIn(respondSelIn), .discExpected(discExpected),
    .phaseChange(phaseChange));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic complete_run();
    if (errTotal == 0 && numChecks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // cut a hang short
  always @(posedge clk) begin
    cycleCnt++;
    if (cycleCnt == 5000) begin
      errTotal++;
      complete_run();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    numChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wrData <= d; wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a; rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    #1;
    d = rdData;
  endtask

  task automatic rdChk(input string what, input logic [7:0] a,
                       input logic [7:0] exp);
    logic [7:0] got;
    rd(a, got);
    chk(what, exp, got);
  endtask

  // bounded poll until a register bit reads clear
  task automatic waitClear(input logic [7:0] a, input int b);
    logic [7:0] got;
    int k;
    k = 0;
    do begin
      rd(a, got);
      k++;
    end while (got[b] !== 1'b0 && k < 40);
  endtask

  // bounded wait for select with busy in the wanted state
  task automatic waitSel(input logic wantBusy);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (!(selOut === 1'b1 && busyOut === wantBusy) && k < 300);
  endtask

  initial begin
    reset = 1'b1; addr = 8'h00; wrData = 8'h00; wrStrobe = 1'b0;
    rdStrobe = 1'b0; errTotal = 0; numChecks = 0; cycleCnt = 0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    // reset values, read-only and reserved bits, unmapped place
    rdChk("ctrl zero", OFF_CTRL_ZERO, CTRL_ZERO_RST);
    rdChk("ctrl one", OFF_CTRL_ONE, CTRL_ONE_RST);
    wr(OFF_CTRL_ONE, 8'h81);
    rdChk("ctrl one reserved", OFF_CTRL_ONE, 8'h00);
    wr(OFF_CTRL_ZERO, 8'hC5);
    rdChk("ctrl zero role", OFF_CTRL_ZERO, 8'hC1);
    rdChk("unmapped", 8'h33, 8'h00);
    // bus reset line held for the software-timed 25 us
    wr(OFF_CTRL_ONE, 8'h08);
    repeat (250) @(posedge clk);
    #1 chk("reset line on", 8'h01, {7'h0, rstOut});
    wr(OFF_CTRL_ONE, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk("reset line off", 8'h00, {7'h0, rstOut});
    // latch driven in target role only with I/O active
    wr(OFF_OUT_LATCH, 8'h5A);
    wr(OFF_CTRL_ONE, 8'h40);
    @(posedge clk);
    #1 chk("target io low", 8'h00, {7'h0, dataOe});
    far.setup(1'b0, 1'b1, 1'b0, 1'b0);
    @(posedge clk);
    #1 chk("target io high", 8'h01, {7'h0, dataOe});
    wr(OFF_CTRL_ZERO, 8'hC0);
    far.setup(1'b0, 1'b0, 1'b0, 1'b0);
    @(posedge clk);
    #1 chk("latch out", 8'h5A, dataOut);
    chk("init drive", 8'h01, {7'h0, dataOe});
    chk("odd parity", {7'h0, ~^8'h5A}, {7'h0, parityOut});
    wr(OFF_CTRL_ONE, 8'h44);
    @(posedge clk);
    #1 chk("even parity", {7'h0, ^8'h5A}, {7'h0, parityOut});
    wr(OFF_CTRL_ONE, 8'h00);
    // initiator parity error: status, ack, auto attention; then crc errors in dt mode
    wr(OFF_CTRL_ZERO, 8'hCA);
    far.sendByte(8'h3C, 1'b1);
    #1 chk("ack", 8'h01, {7'h0, ackOut});
    chk("auto atn", 8'h01, {7'h0, atnOut});
    rdChk("parity err", OFF_INT_STAT0, 8'h01);
    rdChk("err cleared", OFF_INT_STAT0, 8'h00);
    far.sendByte(8'h3C, 1'b0);
    #1 chk("ack goes on", 8'h01, {7'h0, ackOut});
    far.pulsePhase();
    far.setup(1'b0, 1'b0, 1'b1, 1'b0);
    far.crcXfer(1'b0);
    rdChk("crc err", OFF_INT_STAT0, 8'h01);
    far.crcXfer(1'b1);
    rdChk("crc good", OFF_INT_STAT0, 8'h00);
    far.pulsePhase();
    far.setup(1'b0, 1'b0, 1'b0, 1'b0);
    // checking off: no report, no attention
    wr(OFF_CTRL_ZERO, 8'hC2);
    far.sendByte(8'hA5, 1'b1);
    #1 chk("no auto atn", 8'h00, {7'h0, atnOut});
    rdChk("no report", OFF_INT_STAT0, 8'h00);
    // target halt on error, then with halting disabled
    wr(OFF_CTRL_ZERO, 8'hC9);
    far.sendByte(8'h11, 1'b1);
    repeat (2) @(posedge clk);
    #1 chk("halt", 8'h01, {7'h0, haltXfer});
    far.pulsePhase();
    @(posedge clk);
    #1 chk("halt drop", 8'h00, {7'h0, haltXfer});
    far.setAtn(1'b1);
    @(posedge clk);
    #1 chk("atn halt", 8'h01, {7'h0, haltXfer});
    far.setAtn(1'b0);
    far.pulsePhase();
    wr(OFF_CTRL_ONE, 8'h20);
    far.sendByte(8'h11, 1'b1);
    repeat (2) @(posedge clk);
    #1 chk("no halt", 8'h00, {7'h0, haltXfer});
    rd(OFF_INT_STAT0, v);
    wr(OFF_CTRL_ONE, 8'h00);
    // simple arbitration while not connected
    wr(OFF_CTRL_ZERO, 8'h20);
    waitClear(OFF_CTRL_ZERO, START_BIT);
    rdChk("simple won", OFF_BUS_STAT0, 8'h04);
    // full arbitration, selection with attention times out
    wr(OFF_CTRL_ZERO, 8'hF0);
    waitSel(1'b0);
    chk("sel atn", 8'h01, {7'h0, atnOut});
    n = 0;
    while (selOut === 1'b1 && n < 200) begin
      prevAtn = atnOut;
      @(posedge clk);
      #1;
      n++;
    end
    chk("atn before drop", 8'h01, {7'h0, prevAtn});
    chk("atn with sel", 8'h00, {7'h0, atnOut});
    chk("sel released", 8'h00, {7'h0, selOut});
    rdChk("start clear", OFF_CTRL_ZERO, 8'hD0);
    rdChk("not connected", OFF_CTRL_ONE, 8'h00);
    // full arbitration answered by a target, no attention
    far.setup(1'b1, 1'b0, 1'b0, 1'b0);
    wr(OFF_CTRL_ZERO, 8'hE0);
    waitSel(1'b0);
    chk("no sel atn", 8'h00, {7'h0, atnOut});
    waitClear(OFF_CTRL_ZERO, START_BIT);
    rdChk("connected", OFF_CTRL_ONE, 8'h10);
    rdChk("full won", OFF_BUS_STAT0, 8'h04);
    // immediate arbitration after an expected disconnect
    far.setup(1'b1, 1'b0, 1'b0, 1'b1);
    wr(OFF_CTRL_ONE, 8'h12);
    far.freeBus();
    waitSel(1'b1);
    chk("hold busy", 8'h01, {7'h0, busyOut});
    wr(OFF_CTRL_ZERO, 8'hE0);
    waitClear(OFF_CTRL_ONE, IMMARB_BIT);
    rdChk("imm cleared", OFF_CTRL_ONE, 8'h10);
    // forced disconnect by the host
    wr(OFF_CTRL_ONE, 8'h00);
    rdChk("forced off", OFF_CTRL_ONE, 8'h00);
    far.pulseResp();
    rdChk("answered sel", OFF_CTRL_ONE, 8'h10);
    // abort of an immediate arbitration that wins
    wr(OFF_CTRL_ONE, 8'h12);
    wr(OFF_HOST_HOST_INTERRUPT_STATUS_ZERO, 8'h80);
    rd(OFF_BUS_STAT0, v);
    far.freeBus();
    waitSel(1'b1);
    rdChk("abort won", OFF_BUS_STAT0, 8'h04);
    wr(OFF_CTRL_ONE, 8'h10);
    rdChk("abort off", OFF_CTRL_ONE, 8'h00);
    wr(OFF_HOST_HOST_INTERRUPT_STATUS_ZERO, 8'h00);
    far.setup(1'b0, 1'b0, 1'b0, 1'b0);
    far.freeBus();
    complete_run();
  end
endmodule

/* test/scsi_far_side.sv */
// model of the other initiators and targets on the bus
`timescale 1ns/1ps
module scsi_far_side (
  input  wire logic       clk,
  input  wire logic       selOut,
  input  wire logic       busyOut,
  output logic            busyIn,
  output logic            selIn,
  output logic            ioIn,
  output logic            atnIn,
  output logic      [7:0] dataIn,
  output logic            parityIn,
  output logic            reqIn,
  output logic            dtMode,
  output logic            crcReqIn,
  output logic            crcOkIn,
  output logic            crcPendIn,
  output logic            respondSelIn,
  output logic            discExpected,
  output logic            phaseChange
);
  logic answerOn;
  int   waitCnt;

  // idle bus; no crc request is ever left pending by this side
  initial begin
    busyIn = 1'b0; selIn = 1'b0; ioIn = 1'b0; atnIn = 1'b0;
    dataIn = 8'hFF; parityIn = 1'b0; reqIn = 1'b0; dtMode = 1'b0;
    crcReqIn = 1'b0; crcOkIn = 1'b0; crcPendIn = 1'b0;
    respondSelIn = 1'b0; discExpected = 1'b0; phaseChange = 1'b0;
    answerOn = 1'b0; waitCnt = 0;
  end

  // a selected target answers with busy a few cycles later
  always @(posedge clk) begin
    if (answerOn && selOut && !busyOut && !busyIn) begin
      waitCnt <= waitCnt + 1;
      if (waitCnt == 3) busyIn <= 1'b1;
    end else begin
      waitCnt <= 0;
    end
  end

  task automatic setup(input logic ans, input logic io, input logic dt,
                       input logic disc);
    @(posedge clk);
    answerOn <= ans; ioIn <= io; dtMode <= dt; discExpected <= disc;
  endtask

  task automatic freeBus();
    @(posedge clk);
    busyIn <= 1'b0;
  endtask

  // one byte with its request pulse; lines flip once released
  task automatic sendByte(input logic [7:0] d, input logic bad);
    @(posedge clk);
    dataIn <= d; parityIn <= ~^d ^ bad; reqIn <= 1'b1;
    @(posedge clk);
    reqIn <= 1'b0; dataIn <= ~d; parityIn <= ^d ^ bad;
  endtask

  // single crc transfer, never back to back
  task automatic crcXfer(input logic ok);
    @(posedge clk);
    crcReqIn <= 1'b1; crcOkIn <= ok;
    @(posedge clk);
    crcReqIn <= 1'b0; crcOkIn <= ~ok;
  endtask

  task automatic pulsePhase();
    @(posedge clk);
    phaseChange <= 1'b1;
    @(posedge clk);
    phaseChange <= 1'b0;
  endtask

  // attention level seen by a target
  task automatic setAtn(input logic a);
    @(posedge clk);
    atnIn <= a;
  endtask

  // one cycle of an answered bus-initiated selection
  task automatic pulseResp();
    @(posedge clk);
    respondSelIn <= 1'b1;
    @(posedge clk);
    respondSelIn <= 1'b0;
  endtask
endmodule
